/* File: rtl/dacctl_top.sv */
// register file and output control for voltage and current converters
// Functional notes
// - voltage data word holds the 12-bit code in bits 27:16
// - bits 15:12 are fractional code bits, used only in interpolation mode
// - each voltage converter selects supply, internal or external reference
// - five current converters, each with an 11-bit code
// - after any reset current converters are powered down, output undriven
// - fault output set while reference resistor is below half expected value
// - thermal trip disables every current output stage, rest keeps running
// - thermal trip raises an interrupt and sets the trip flag
// - thermal shutdown path does not depend on core logic
// - trip flag survives software and watchdog resets
// - trip flag clears on hardware reset or writing 0 to status
// - update source bit 5 (bit 3 for current converters): set paces by timer one, clear by core clock
// - clear bit 4 (bit 2 for current converters) low forces data register to zero
// - thermal interrupt disable bit 1 low lets trip raise an interrupt
// - shutdown disable bit 0 low lets trip disable current outputs
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module dacctl_top
   import dacctl_pkg::*;
(
   // clock and reset
   input  wire logic                              mclk,
   input  wire logic                              nrst,
   input  wire logic                              soft_reset,
   // apb slave
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [ADDR_W-1:0]                 paddr,
   input  wire logic [DATA_W-1:0]                 pwdata,
   output logic      [DATA_W-1:0]                 prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   // analog side inputs
   input  wire logic                              timer_one_tick,
   input  wire logic                              thermal_trip,
   input  wire logic                              rref_low_cmp,
   // voltage converter outputs
   output logic      [VDAC_N-1:0][VCODE_W-1:0]    vdac_code,
   output logic      [VDAC_N-1:0][VFRAC_W-1:0]    vdac_frac,
   output dacctl_ref_t [VDAC_N-1:0]               vdac_ref_sel,
   output logic      [VDAC_N-1:0]                 vdac_power_up,
   output logic      [VDAC_N-1:0]                 vdac_interp,
   output logic      [VDAC_N-1:0]                 vdac_interp_fast,
   output logic      [VDAC_N-1:0]                 vdac_buf_low_power,
   output logic      [VDAC_N-1:0]                 vdac_bypass,
   // current converter outputs
   output logic      [IDAC_N-1:0][ICODE_W-1:0]    idac_code,
   output logic      [IDAC_N-1:0]                 idac_drive_en,
   output logic                                   idac_shutdown,
   // status and interrupt
   output logic                                   rref_fault,
   output logic                                   irq
);

   logic [VDAC_N-1:0][VCODE_W+VFRAC_W-1:0] vdat_reg;
   logic [VDAC_N-1:0][VCODE_W+VFRAC_W-1:0] vdat_next;
   logic [VDAC_N-1:0][VCODE_W+VFRAC_W-1:0] vout_reg;
   logic [VDAC_N-1:0][VCODE_W+VFRAC_W-1:0] vout_next;
   dacctl_vctrl_t [VDAC_N-1:0]              vctrl_reg;
   dacctl_vctrl_t [VDAC_N-1:0]              vctrl_next;
   logic [IDAC_N-1:0][ICODE_W-1:0]          idat_reg;
   logic [IDAC_N-1:0][ICODE_W-1:0]          idat_next;
   logic [IDAC_N-1:0][ICODE_W-1:0]          iout_reg;
   logic [IDAC_N-1:0][ICODE_W-1:0]          iout_next;
   dacctl_ictrl_t [IDAC_N-1:0]              ictrl_reg;
   dacctl_ictrl_t [IDAC_N-1:0]              ictrl_next;
   logic                                    sd_dis_reg;
   logic                                    sd_dis_next;
   logic                                    irq_dis_reg;
   logic                                    irq_dis_next;
   logic [IRQ_W-1:0]                        istat_reg;
   logic [IRQ_W-1:0]                        istat_next;
   logic [IRQ_W-1:0]                        ien_reg;
   logic [IRQ_W-1:0]                        ien_next;
   logic                                    fault_reg;
   logic                                    fault_next;
   logic [DATA_W-1:0]                       prdata_reg;
   logic [DATA_W-1:0]                       prdata_next;

   logic             wr_access;
   logic             rd_setup;
   logic             hit_vdat;
   logic             hit_vctrl;
   logic             hit_idat;
   logic             hit_ictrl;
   logic             hit_tctrl;
   logic             hit_status;
   logic             hit_istat;
   logic             hit_iclr;
   logic             hit_ien;
   logic             mapped;
   logic [2:0]       vidx;
   logic [2:0]       iidx;
   logic [DATA_W-1:0] rd_word;
   logic             flag_clear;
   logic             trip_flag;
   logic             trip_event;
   logic             fault_event;
   logic [IRQ_W-1:0] events;

   // zero-wait slave: read data is captured in the setup cycle
   assign wr_access = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;

   always_comb
   begin
      hit_vdat = 1'b0;
      hit_vctrl = 1'b0;
      hit_idat = 1'b0;
      hit_ictrl = 1'b0;
      hit_tctrl = 1'b0;
      hit_status = 1'b0;
      hit_istat = 1'b0;
      hit_iclr = 1'b0;
      hit_ien = 1'b0;
      vidx = {1'b0, paddr[3:2]};
      iidx = paddr[4:2];
      if (paddr[1:0] != 2'h0)
      begin
         hit_vdat = 1'b0;
      end
      else if (paddr >= VDAT_BASE && paddr <= VDAT_LAST)
      begin
         hit_vdat = 1'b1;
      end
      else if (paddr >= VCTRL_BASE && paddr <= VCTRL_LAST)
      begin
         hit_vctrl = 1'b1;
      end
      else if (paddr >= IDAT_BASE && paddr <= IDAT_LAST)
      begin
         hit_idat = 1'b1;
      end
      else if (paddr >= ICTRL_BASE && paddr <= ICTRL_LAST)
      begin
         hit_ictrl = 1'b1;
      end
      else if (paddr == TCTRL_ADDR)
      begin
         hit_tctrl = 1'b1;
      end
      else if (paddr == STATUS_ADDR)
      begin
         hit_status = 1'b1;
      end
      else if (paddr == IRQ_STAT_ADDR)
      begin
         hit_istat = 1'b1;
      end
      else if (paddr == IRQ_CLR_ADDR)
      begin
         hit_iclr = 1'b1;
      end
      else if (paddr == IRQ_EN_ADDR)
      begin
         hit_ien = 1'b1;
      end
      mapped = hit_vdat | hit_vctrl | hit_idat | hit_ictrl | hit_tctrl | hit_status | hit_istat | hit_iclr | hit_ien;
   end

   always_comb
   begin
      rd_word = '0;
      if (hit_vdat)
      begin
         rd_word[VCODE_MSB:VFRAC_LSB] = vdat_reg[vidx[1:0]];
      end
      else if (hit_vctrl)
      begin
         rd_word[CTRL_W-1:0] = vctrl_reg[vidx[1:0]];
      end
      else if (hit_idat)
      begin
         rd_word[ICODE_MSB:ICODE_LSB] = idat_reg[iidx];
      end
      else if (hit_ictrl)
      begin
         rd_word[CTRL_W-1:0] = ictrl_reg[iidx];
      end
      else if (hit_tctrl)
      begin
         rd_word[TCTRL_SD_DIS_BIT] = sd_dis_reg;
         rd_word[TCTRL_IRQ_DIS_BIT] = irq_dis_reg;
      end
      else if (hit_status)
      begin
         rd_word[STA_TRIP_BIT] = trip_flag;
         rd_word[STA_FAULT_BIT] = fault_reg;
      end
      else if (hit_istat)
      begin
         rd_word[IRQ_W-1:0] = istat_reg;
      end
      else if (hit_ien)
      begin
         rd_word[IRQ_W-1:0] = ien_reg;
      end
      prdata_next = rd_setup ? rd_word : prdata_reg;
   end

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_reg;

   // voltage converters
   genvar gv;
   generate
      for (gv = 0; gv < VDAC_N; gv++)
      begin : g_vdac
         always_comb
         begin
            vdat_next[gv] = vdat_reg[gv];
            vctrl_next[gv] = vctrl_reg[gv];
            vout_next[gv] = vout_reg[gv];
            if (soft_reset)
            begin
               vdat_next[gv] = '0;
               vctrl_next[gv] = VCTRL_RST;
               vout_next[gv] = '0;
            end
            else
            begin
               if (wr_access && hit_vdat && vidx == gv)
               begin
                  vdat_next[gv] = pwdata[VCODE_MSB:VFRAC_LSB];
               end
               if (wr_access && hit_vctrl && vidx == gv)
               begin
                  vctrl_next[gv] = pwdata[CTRL_W-1:0];
               end
               if (!vctrl_reg[gv].dac_data_clear_n)
               begin
                  vdat_next[gv] = '0;
               end
               if (!vctrl_reg[gv].dac_update_source || timer_one_tick)
               begin
                  vout_next[gv] = vdat_reg[gv];
               end
            end
         end

         always_ff @(posedge mclk or negedge nrst)
         begin
            if (!nrst)
            begin
               vdat_reg[gv] <= '0;
               vctrl_reg[gv] <= VCTRL_RST;
               vout_reg[gv] <= '0;
            end
            else
            begin
               vdat_reg[gv] <= vdat_next[gv];
               vctrl_reg[gv] <= vctrl_next[gv];
               vout_reg[gv] <= vout_next[gv];
            end
         end

         assign vdac_code[gv] = vout_reg[gv][VCODE_W+VFRAC_W-1:VFRAC_W];
         // fraction bits reach the converter only while interpolating
         assign vdac_frac[gv] = vctrl_reg[gv].normal_mode ? '0 : vout_reg[gv][VFRAC_W-1:0];
         assign vdac_ref_sel[gv] = (vctrl_reg[gv].range == RANGE_INTERNAL) ? DACCTL_REF_INTERNAL :
                                   (vctrl_reg[gv].range == RANGE_SUPPLY) ? DACCTL_REF_SUPPLY :
                                   DACCTL_REF_EXTERNAL;
         assign vdac_power_up[gv] = ~vctrl_reg[gv].power_down;
         assign vdac_interp[gv] = ~vctrl_reg[gv].normal_mode;
         assign vdac_interp_fast[gv] = vctrl_reg[gv].rate_fast;
         assign vdac_buf_low_power[gv] = vctrl_reg[gv].buf_low_power;
         assign vdac_bypass[gv] = vctrl_reg[gv].bypass;
      end
   endgenerate

   // current converters
   genvar gi;
   generate
      for (gi = 0; gi < IDAC_N; gi++)
      begin : g_idac
         always_comb
         begin
            idat_next[gi] = idat_reg[gi];
            ictrl_next[gi] = ictrl_reg[gi];
            iout_next[gi] = iout_reg[gi];
            if (soft_reset)
            begin
               idat_next[gi] = '0;
               ictrl_next[gi] = ICTRL_RST;
               iout_next[gi] = '0;
            end
            else
            begin
               if (wr_access && hit_idat && iidx == gi)
               begin
                  idat_next[gi] = pwdata[ICODE_MSB:ICODE_LSB];
               end
               if (wr_access && hit_ictrl && iidx == gi)
               begin
                  ictrl_next[gi] = pwdata[CTRL_W-1:0];
               end
               if (!ictrl_reg[gi].dac_data_clear_n)
               begin
                  idat_next[gi] = '0;
               end
               if (!ictrl_reg[gi].dac_update_source || timer_one_tick)
               begin
                  iout_next[gi] = idat_reg[gi];
               end
            end
         end

         always_ff @(posedge mclk or negedge nrst)
         begin
            if (!nrst)
            begin
               idat_reg[gi] <= '0;
               ictrl_reg[gi] <= ICTRL_RST;
               iout_reg[gi] <= '0;
            end
            else
            begin
               idat_reg[gi] <= idat_next[gi];
               ictrl_reg[gi] <= ictrl_next[gi];
               iout_reg[gi] <= iout_next[gi];
            end
         end

         assign idac_code[gi] = iout_reg[gi];
         assign idac_drive_en[gi] = ~ictrl_reg[gi].power_down & ~idac_shutdown;
      end
   endgenerate

   // thermal control, fault and interrupt state
   assign flag_clear = wr_access & hit_status & ~pwdata[STA_TRIP_BIT];
   assign fault_event = rref_low_cmp & ~fault_reg;
   assign events = {fault_event, trip_event};

   always_comb
   begin
      sd_dis_next = sd_dis_reg;
      irq_dis_next = irq_dis_reg;
      ien_next = ien_reg;
      fault_next = rref_low_cmp;
      // a new event in the clearing cycle stays set
      istat_next = (istat_reg & ~((wr_access && hit_iclr) ? pwdata[IRQ_W-1:0] : '0)) | events;
      if (soft_reset)
      begin
         sd_dis_next = 1'b0;
         irq_dis_next = 1'b0;
         ien_next = '0;
         istat_next = '0;
      end
      else
      begin
         if (wr_access && hit_tctrl)
         begin
            sd_dis_next = pwdata[TCTRL_SD_DIS_BIT];
            irq_dis_next = pwdata[TCTRL_IRQ_DIS_BIT];
         end
         if (wr_access && hit_ien)
         begin
            ien_next = pwdata[IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         sd_dis_reg <= 1'b0;
         irq_dis_reg <= 1'b0;
         ien_reg <= '0;
         istat_reg <= '0;
         fault_reg <= 1'b0;
         prdata_reg <= '0;
      end
      else
      begin
         sd_dis_reg <= sd_dis_next;
         irq_dis_reg <= irq_dis_next;
         ien_reg <= ien_next;
         istat_reg <= istat_next;
         fault_reg <= fault_next;
         prdata_reg <= prdata_next;
      end
   end

   assign rref_fault = fault_reg;
   assign irq = |(istat_reg & ien_reg);

   dacctl_thermal u_thermal
   (
      .mclk              (mclk),
      .nrst              (nrst),
      .thermal_trip      (thermal_trip),
      .shutdown_disable  (sd_dis_reg),
      .irq_disable       (irq_dis_reg),
      .flag_clear        (flag_clear),
      .idac_shutdown     (idac_shutdown),
      .thermal_trip_flag (trip_flag),
      .trip_event        (trip_event)
   );

endmodule // dacctl_top

/* File: rtl/dacctl_pkg.sv */
// constants, field layouts and types for the converter control block
package dacctl_pkg;

   // channel counts and code widths
   localparam int VDAC_N = 4;
   localparam int IDAC_N = 5;
   localparam int VCODE_W = 12;
   localparam int VFRAC_W = 4;
   localparam int ICODE_W = 11;
   localparam int CTRL_W = 9;
   localparam int IRQ_W = 2;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // voltage converter data word fields
   localparam int VCODE_MSB = 27;
   localparam int VCODE_LSB = 16;
   localparam int VFRAC_MSB = 15;
   localparam int VFRAC_LSB = 12;
   // current converter data word fields
   localparam int ICODE_MSB = 26;
   localparam int ICODE_LSB = 16;

   // register map, byte addresses
   localparam logic [ADDR_W-1:0] VDAT_BASE = 8'h00;
   localparam logic [ADDR_W-1:0] VCTRL_BASE = 8'h10;
   localparam logic [ADDR_W-1:0] IDAT_BASE = 8'h20;
   localparam logic [ADDR_W-1:0] ICTRL_BASE = 8'h40;
   localparam logic [ADDR_W-1:0] TCTRL_ADDR = 8'h60;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h64;
   localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 8'h68;
   localparam logic [ADDR_W-1:0] IRQ_CLR_ADDR = 8'h6C;
   localparam logic [ADDR_W-1:0] IRQ_EN_ADDR = 8'h70;
   localparam logic [ADDR_W-1:0] VDAT_LAST = 8'h0C;
   localparam logic [ADDR_W-1:0] VCTRL_LAST = 8'h1C;
   localparam logic [ADDR_W-1:0] IDAT_LAST = 8'h30;
   localparam logic [ADDR_W-1:0] ICTRL_LAST = 8'h50;

   // bit positions in status, interrupt and thermal control words
   localparam int STA_TRIP_BIT = 0;
   localparam int STA_FAULT_BIT = 1;
   localparam int IRQ_TRIP_BIT = 0;
   localparam int IRQ_FAULT_BIT = 1;
   localparam int TCTRL_SD_DIS_BIT = 0;
   localparam int TCTRL_IRQ_DIS_BIT = 1;

   // voltage converter control word, bit 8 down to bit 0
   typedef struct packed {
      logic       power_down;
      logic       buf_low_power;
      logic       bypass;
      logic       dac_update_source;
      logic       dac_data_clear_n;
      logic       normal_mode;
      logic       rate_fast;
      logic [1:0] range;
   } dacctl_vctrl_t;

   // current converter control word, bit 8 down to bit 0
   typedef struct packed {
      logic [1:0] shuffle_mode;
      logic       msb_shuffle;
      logic       lsb_shuffle;
      logic       power_down;
      logic       dac_update_source;
      logic       dac_data_clear_n;
      logic       mode;
      logic       rsvd;
   } dacctl_ictrl_t;

   localparam logic [CTRL_W-1:0] VCTRL_RST = 9'h100;
   localparam logic [CTRL_W-1:0] ICTRL_RST = 9'h010;

   // range field codes
   localparam logic [1:0] RANGE_INTERNAL = 2'h0;
   localparam logic [1:0] RANGE_SUPPLY = 2'h3;

   typedef enum logic [1:0] {
      DACCTL_REF_INTERNAL,
      DACCTL_REF_EXTERNAL,
      DACCTL_REF_SUPPLY
   } dacctl_ref_t;

endpackage

/* File: rtl/dacctl_thermal.sv */
// thermal trip path: output shutdown, sticky trip flag, trip event
`timescale 1ns/1ps
module dacctl_thermal
   import dacctl_pkg::*;
(
   // clock and power-on/hardware reset
   input  wire logic mclk,
   input  wire logic nrst,
   // sensor and control
   input  wire logic thermal_trip,
   input  wire logic shutdown_disable,
   input  wire logic irq_disable,
   input  wire logic flag_clear,
   // results
   output logic      idac_shutdown,
   output logic      thermal_trip_flag,
   output logic      trip_event
);

   logic trip_prev_reg;
   logic trip_prev_next;
   logic flag_reg;
   logic flag_next;
   logic event_reg;
   logic event_next;

   // no register in this path, so a hung core cannot hold the stages on
   assign idac_shutdown = thermal_trip & ~shutdown_disable;

   always_comb
   begin
      trip_prev_next = thermal_trip;
      event_next = thermal_trip & ~trip_prev_reg & ~irq_disable;
      flag_next = flag_reg;
      // a trip still present beats the software clear
      if (thermal_trip)
      begin
         flag_next = 1'b1;
      end
      else if (flag_clear)
      begin
         flag_next = 1'b0;
      end
   end

   // only nrst reaches this flag; soft and watchdog resets do not
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         trip_prev_reg <= 1'b0;
         flag_reg <= 1'b0;
         event_reg <= 1'b0;
      end
      else
      begin
         trip_prev_reg <= trip_prev_next;
         flag_reg <= flag_next;
         event_reg <= event_next;
      end
   end

   assign thermal_trip_flag = flag_reg;
   assign trip_event = event_reg;

endmodule // dacctl_thermal

/* File: sim/dacctl_assertions.sv */
// port-level property checker for the converter control top
`timescale 1ns/1ps
module dacctl_assertions
   import dacctl_pkg::*;
(
   // clock and resets
   input wire logic                           mclk,
   input wire logic                           nrst,
   // apb
   input wire logic                           psel,
   input wire logic                           penable,
   input wire logic                           pwrite,
   input wire logic [ADDR_W-1:0]              paddr,
   input wire logic [DATA_W-1:0]              prdata,
   input wire logic                           pready,
   input wire logic                           pslverr,
   // analog side
   input wire logic                           thermal_trip,
   input wire logic                           rref_low_cmp,
   input wire logic                           rref_fault,
   input wire logic                           idac_shutdown,
   input wire logic [IDAC_N-1:0]              idac_drive_en,
   // voltage converters
   input wire logic [VDAC_N-1:0]              vdac_power_up,
   input wire logic [VDAC_N-1:0]              vdac_interp,
   input wire logic [VDAC_N-1:0][VFRAC_W-1:0] vdac_frac,
   input wire dacctl_ref_t [VDAC_N-1:0]       vdac_ref_sel
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   AST_SD_OFF: assert property (idac_shutdown |-> idac_drive_en == 5'h00)
      else $error("output stage drives during shutdown");
   AST_SD_CAUSE: assert property (!thermal_trip |-> !idac_shutdown)
      else $error("shutdown without thermal trip");
   AST_FAULT: assert property (1'b1 |=> rref_fault == $past(rref_low_cmp))
      else $error("fault output does not follow comparator");
   AST_RST_PD: assert property ($rose(nrst) |-> idac_drive_en == 5'h00 && vdac_power_up == 4'h0)
      else $error("converter powered after reset");
   AST_FRAC: assert property (!vdac_interp[1] |-> vdac_frac[1] == 4'h0)
      else $error("fraction bits outside interpolation");
   AST_REF: assert property (vdac_ref_sel[1] != 2'h3)
      else $error("illegal reference select");
   AST_PREADY: assert property (psel && penable |-> pready)
      else $error("access phase not ready");
   AST_SETUP_OK: assert property (psel && !penable |-> !pslverr)
      else $error("error flag in setup phase");
   AST_UNALIGNED: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned access accepted");
   AST_RDZERO: assert property (psel && penable && !pwrite && paddr <= VDAT_LAST
      |-> (prdata & 32'hF000_0FFF) == 32'h0)
      else $error("reserved data bits read nonzero");
endmodule // dacctl_assertions

bind dacctl_top dacctl_assertions dacctl_assertions_inst (.mclk(mclk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .thermal_trip(thermal_trip), .rref_low_cmp(rref_low_cmp), .rref_fault(rref_fault),
   .idac_shutdown(idac_shutdown), .idac_drive_en(idac_drive_en), .vdac_power_up(vdac_power_up),
   .vdac_interp(vdac_interp), .vdac_frac(vdac_frac), .vdac_ref_sel(vdac_ref_sel));

/* File: sim/dacctl_analog_model.sv */
// behavioural die sensor and reference resistor comparator
`timescale 1ns/1ps
module dacctl_analog_model
(
   // clock
   input wire logic  mclk,
   // scenario controls
   input wire logic  overheat,
   input wire logic  rref_short,
   // comparator outputs
   output logic      thermal_trip = 1'b0,
   output logic      rref_low_cmp = 1'b0
);
   // analog comparators settle a clock late, never in the same edge
   always_ff @(posedge mclk)
   begin
      thermal_trip <= overheat;
      rref_low_cmp <= rref_short;
   end
endmodule // dacctl_analog_model

/* File: sim/dacctl_tb.sv */
// self-checking bench for the converter control top
`timescale 1ns/1ps
module dacctl_tb
   import dacctl_pkg::*;
();
   logic                           mclk = 1'b0, nrst = 1'b0, soft_reset = 1'b0, timer_one_tick = 1'b0;
   logic                           psel = 1'b0, penable = 1'b0, pwrite = 1'b0, overheat = 1'b0;
   logic                           rref_short = 1'b0, pready, pslverr, slv, thermal_trip, rref_low_cmp;
   logic [ADDR_W-1:0]              paddr = '0;
   logic [DATA_W-1:0]              pwdata = '0, prdata, rd;
   logic [VDAC_N-1:0][VCODE_W-1:0] vdac_code;
   logic [VDAC_N-1:0][VFRAC_W-1:0] vdac_frac;
   dacctl_ref_t [VDAC_N-1:0]       vdac_ref_sel;
   logic [VDAC_N-1:0]              vdac_power_up, vdac_interp, vfast, vlp, vbyp;
   logic [IDAC_N-1:0][ICODE_W-1:0] idac_code;
   logic [IDAC_N-1:0]              idac_drive_en;
   logic                           idac_shutdown, rref_fault, irq;
   int                             err_count = 0, checked = 0;

   always #25 mclk = ~mclk;

   dacctl_top dacctl_top_inst (.mclk(mclk), .nrst(nrst), .soft_reset(soft_reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_one_tick(timer_one_tick), .thermal_trip(thermal_trip),
      .rref_low_cmp(rref_low_cmp), .vdac_code(vdac_code), .vdac_frac(vdac_frac), .vdac_ref_sel(vdac_ref_sel),
      .vdac_power_up(vdac_power_up), .vdac_interp(vdac_interp), .vdac_interp_fast(vfast), .vdac_buf_low_power(vlp),
      .vdac_bypass(vbyp), .idac_code(idac_code), .idac_drive_en(idac_drive_en), .idac_shutdown(idac_shutdown),
      .rref_fault(rref_fault), .irq(irq));

   dacctl_analog_model dacctl_analog_model_inst (.mclk(mclk), .overheat(overheat), .rref_short(rref_short),
      .thermal_trip(thermal_trip), .rref_low_cmp(rref_low_cmp));

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
      begin
         @(posedge mclk);
      end
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task rst;
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      settle(1);
   endtask

   task t_reset;
      chk(idac_drive_en, 0);
      chk(vdac_power_up, 0);
      rchk(VCTRL_BASE, 32'h100);
      rchk(ICTRL_BASE + 8'h10, 32'h010);
   endtask

   task t_vdac;
      int i;
      wr(VCTRL_BASE + 8'h04, 32'h018);
      wr(VDAT_BASE + 8'h04, 32'hFFFF_FFFF);
      rchk(VDAT_BASE + 8'h04, 32'h0FFF_F000);
      settle(2);
      chk(vdac_code[1], 12'hFFF);
      chk(vdac_frac[1], 4'h0);
      wr(VCTRL_BASE + 8'h04, 32'h0D4);
      settle(2);
      chk(vdac_frac[1], 4'hF);
      chk({vlp[1], vbyp[1], vfast[1]}, 3'h7);
      for (i = 0; i < 4; i++)
      begin
         wr(VCTRL_BASE + 8'h04, 32'h018 | i);
         settle(1);
         chk(vdac_ref_sel[1], i == 0 ? DACCTL_REF_INTERNAL : (i == 3 ? DACCTL_REF_SUPPLY : DACCTL_REF_EXTERNAL));
      end
      wr(VCTRL_BASE + 8'h04, 32'h008);
      settle(2);
      rchk(VDAT_BASE + 8'h04, 32'h0);
      chk(vdac_code[1], 12'h000);
   endtask

   task t_timer;
      wr(VCTRL_BASE + 8'h08, 32'h038);
      wr(VDAT_BASE + 8'h08, 32'h0123_0000);
      settle(3);
      chk(vdac_code[2], 12'h000);
      @(posedge mclk);
      timer_one_tick <= 1'b1;
      @(posedge mclk);
      timer_one_tick <= 1'b0;
      settle(1);
      chk(vdac_code[2], 12'h123);
   endtask

   task t_idac;
      int i;
      for (i = 0; i < IDAC_N; i++)
      begin
         wr(ICTRL_BASE + 8'(4 * i), 32'h004);
         wr(IDAT_BASE + 8'(4 * i), (32'h400 | i) << 16);
         settle(2);
         chk(idac_code[i], 32'h400 | i);
         chk(idac_drive_en[i], 1'b1);
      end
   endtask

   task t_refuse;
      apb(1'b0, 8'h80, 32'h0);
      chk(rd, 32'h0);
      chk(slv, 1'b1);
      apb(1'b0, 8'h03, 32'h0);
      chk(slv, 1'b1);
   endtask

   task trip(input logic v);
      @(posedge mclk);
      overheat <= v;
      settle(4);
   endtask

   task t_thermal;
      trip(1'b1);
      chk(idac_shutdown, 1'b1);
      chk(idac_drive_en, 5'h00);
      chk(irq, 1'b0);
      rchk(IRQ_STAT_ADDR, 32'h1);
      wr(IRQ_EN_ADDR, 32'h1);
      settle(1);
      chk(irq, 1'b1);
      trip(1'b0);
      chk(idac_drive_en, 5'h1F);
      wr(IRQ_CLR_ADDR, 32'h1);
      settle(1);
      chk(irq, 1'b0);
      @(posedge mclk);
      soft_reset <= 1'b1;
      @(posedge mclk);
      soft_reset <= 1'b0;
      settle(1);
      rchk(STATUS_ADDR, 32'h1);
      chk(idac_drive_en, 5'h00);
      wr(STATUS_ADDR, 32'h0);
      rchk(STATUS_ADDR, 32'h0);
      wr(TCTRL_ADDR, 32'h2);
      wr(IRQ_EN_ADDR, 32'h1);
      trip(1'b1);
      chk(irq, 1'b0);
      rchk(IRQ_STAT_ADDR, 32'h0);
      wr(TCTRL_ADDR, 32'h1);
      settle(1);
      chk(idac_shutdown, 1'b0);
      trip(1'b0);
      rst();
      rchk(STATUS_ADDR, 32'h0);
   endtask

   task t_fault;
      wr(IRQ_EN_ADDR, 32'h2);
      @(posedge mclk);
      rref_short <= 1'b1;
      settle(4);
      chk(rref_fault, 1'b1);
      chk(irq, 1'b1);
      rchk(STATUS_ADDR, 32'h2);
      @(posedge mclk);
      rref_short <= 1'b0;
      settle(3);
      chk(rref_fault, 1'b0);
   endtask

   task results;
      $display("errors %0d of %0d checks", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      rst();
      t_reset();
      t_vdac();
      t_timer();
      t_idac();
      t_refuse();
      t_thermal();
      t_fault();
      results();
   end

   // whole run is a few hundred cycles; this margin only catches a hang
   initial
   begin
      repeat (20000) @(posedge mclk);
      err_count++;
      results();
   end
endmodule // dacctl_tb
